/* issr_pkg.sv */
package issr_pkg;
  localparam logic [11:0] ADDR_BUS_PHASE_REPORT = 12'h008;
  localparam logic [11:0] ADDR_BUFFER_AND_PENDING_REPORT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h024;
  localparam logic [11:0] ADDR_CONTROL = 12'h028;
  // state register fields
  localparam int PHASE_LSB = 5;
  localparam int BUS_HELD_BIT = 4;
  localparam int NOT_ACKNOWLEDGED_FLAG_BIT = 3;
  localparam int TRANSMITTER_BIT = 2;
  localparam int CONTROLLER_BIT = 1;
  localparam int BUSY_BIT = 0;
  // status register fields
  localparam int RX_VALID_BIT = 8;
  localparam int TX_LEVEL_BIT = 7;
  localparam int TX_COMPLETE_BIT = 6;
  localparam int ABORT_PEND_BIT = 5;
  localparam int CONT_PEND_BIT = 4;
  localparam int NACK_PEND_BIT = 3;
  localparam int ACK_PEND_BIT = 2;
  localparam int STOP_PEND_BIT = 1;
  localparam int START_PEND_BIT = 0;
  // interrupt status bits
  localparam int IRQ_TX_COMPLETE = 0;
  localparam int IRQ_NACK = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_WIDTH = 3;
  localparam logic [31:0] STATE_RESET = 32'h0000_0001;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0080;
  // bus idle timeout, in microseconds
  localparam int IDLE_TIMEOUT_US = 50;
  localparam int CLK_MHZ = 10;
  localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_US * CLK_MHZ;
  localparam logic [15:0] IDLE_TIMEOUT_RESET = 16'(IDLE_TIMEOUT_CYCLES);

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_WAITING = 3'h1,
    PH_START = 3'h2,
    PH_ADDRESS = 3'h3,
    PH_ADDRESS_ACK = 3'h4,
    PH_DATA = 3'h5,
    PH_DATA_ACK = 3'h6
  } issr_phase_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic ack;
    logic nack;
    logic cont;
    logic abort;
    logic clear_pending;
  } issr_cmd_t;

  typedef struct packed {
    logic start_sent;
    logic stop_sent;
    logic ack_sent;
    logic nack_sent;
    logic cont_done;
    logic abort_done;
  } issr_done_t;
endpackage

/* issr_pending.sv */
`timescale 1ns/100ps
`default_nettype none
// one sticky pending flag per command; a new request wins over a same-cycle completion
module issr_pending (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic [5:0] req, // command requests
  input wire logic [5:0] done, // command carried out
  input wire logic clear_all, // drop all pending
  output logic [5:0] pend // pending flags
);
  logic [5:0] pend_reg;
  logic [5:0] pend_next;

  for (genvar i = 0; i < 6; i++) begin : g_flag
    always_comb begin
      pend_next[i] = pend_reg[i];
      if (clear_all || done[i]) begin
        pend_next[i] = 1'b0;
      end
      if (req[i]) begin
        pend_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 6'h00;
    end else if (ce) begin
      pend_reg <= pend_next;
    end
  end

  assign pend = pend_reg;
endmodule
`default_nettype wire

/* issr_idle_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// counts quiet bus cycles while busy; pulses once when the timeout runs out
module issr_idle_timer (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic busy, // busy flag
  input wire logic bus_activity, // line change seen
  input wire logic [15:0] limit, // timeout length
  output logic expired // one-cycle pulse
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic expired_reg;
  logic expired_next;

  always_comb begin
    cnt_next = cnt_reg;
    expired_next = 1'b0;
    if (!busy || bus_activity || limit == 16'h0000) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg + 16'h0001 >= limit) begin
      cnt_next = 16'h0000;
      expired_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      expired_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;
endmodule
`default_nettype wire

/* issr_top.sv */
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module issr_top (
  input wire logic CLK_SYS, // 10 MHz clock
  input wire logic RSTN, // async reset, active low
  input wire logic CE, // clock enable
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire issr_pkg::issr_cmd_t CMD, // command strobes
  input wire issr_pkg::issr_done_t DONE, // engine completion strobes
  input wire issr_pkg::issr_phase_t ENGINE_PHASE, // engine transfer phase
  input wire logic ENGINE_ACTIVE, // engine not idle
  input wire logic BUS_START_SEEN, // start on bus
  input wire logic BUS_STOP_SEEN, // stop on bus
  input wire logic BUS_ACTIVITY, // any line change
  input wire logic HOLDING_BUS, // this module holds scl low
  input wire logic NACK_RECEIVED, // nack sampled in ack slot
  input wire logic TRANSMITTING, // acting as transmitter
  input wire logic CONTROLLER_ROLE, // acting as controller
  input wire logic RX_NOT_EMPTY, // receive buffer occupied
  input wire logic TX_EMPTY, // transmit buffer empty
  input wire logic TX_FULL, // transmit buffer full
  input wire logic TRANSFER_END, // transfer finished pulse
  input wire logic TRANSFER_BEGIN, // new transfer pulse
  output logic ISSUE_START, // bus idle seen while waiting
  output logic ABORT_BUSY, // busy forced clear
  output logic IRQ // level interrupt
);
  logic [31:0] state_reg, state_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic busy_reg, busy_next;
  logic txc_reg, txc_next;
  logic issue_start_reg, issue_start_next;
  logic abort_busy_reg, abort_busy_next;
  logic [issr_pkg::IRQ_WIDTH-1:0] irq_stat_reg, irq_stat_next;
  logic [issr_pkg::IRQ_WIDTH-1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic [15:0] timeout_reg, timeout_next;
  logic [5:0] pend;
  logic [5:0] pend_req;
  logic [5:0] pend_done;
  logic timeout_hit;
  logic access;
  logic wr;
  logic [issr_pkg::IRQ_WIDTH-1:0] irq_events;
  issr_pkg::issr_phase_t phase;

  assign access = PSEL && PENABLE && !pready_reg;
  // a write lands on the edge at which the master sees ready, never a cycle earlier
  assign wr = PSEL && PENABLE && PWRITE && pready_reg;

  // flags are ordered start..abort to match status bits 0..5
  assign pend_req = {CMD.abort, CMD.cont, CMD.nack, CMD.ack, CMD.stop, CMD.start};
  assign pend_done = {DONE.abort_done, DONE.cont_done, DONE.nack_sent, DONE.ack_sent,
                      DONE.stop_sent, DONE.start_sent};

  issr_pending u_pending (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .ce(CE),
    .req(pend_req),
    .done(pend_done),
    .clear_all(CMD.clear_pending),
    .pend(pend)
  );

  issr_idle_timer u_timer (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .ce(CE),
    .busy(busy_reg),
    .bus_activity(BUS_ACTIVITY),
    .limit(timeout_reg),
    .expired(timeout_hit)
  );

  // phase is forced to idle unless the engine is active and reports a code no higher than PH_DATA_ACK
  always_comb begin
    phase = issr_pkg::PH_IDLE;
    if (ENGINE_ACTIVE && ENGINE_PHASE <= issr_pkg::PH_DATA_ACK) begin
      phase = ENGINE_PHASE;
    end
  end

  // bus busy: start sets, stop or abort or timeout clears; set wins
  always_comb begin
    busy_next = busy_reg;
    abort_busy_next = 1'b0;
    if (BUS_STOP_SEEN) begin
      busy_next = 1'b0;
    end
    if (DONE.abort_done || timeout_hit) begin
      busy_next = 1'b0;
      abort_busy_next = busy_reg;
    end
    if (BUS_START_SEEN || HOLDING_BUS) begin
      busy_next = 1'b1;
    end
  end

  // waiting phase fires its start only once the bus is free
  always_comb begin
    issue_start_next = (phase == issr_pkg::PH_WAITING) && !busy_reg && pend[issr_pkg::START_PEND_BIT];
  end

  always_comb begin
    txc_next = txc_reg;
    if (TRANSFER_BEGIN) begin
      txc_next = 1'b0;
    end
    if (TRANSFER_END && TX_EMPTY) begin
      txc_next = 1'b1;
    end
  end

  always_comb begin
    state_next = 32'h0000_0000;
    state_next[issr_pkg::PHASE_LSB +: 3] = phase;
    state_next[issr_pkg::BUS_HELD_BIT] = HOLDING_BUS;
    state_next[issr_pkg::NOT_ACKNOWLEDGED_FLAG_BIT] = NACK_RECEIVED &&
      (phase == issr_pkg::PH_ADDRESS_ACK || phase == issr_pkg::PH_DATA_ACK);
    state_next[issr_pkg::TRANSMITTER_BIT] = TRANSMITTING;
    state_next[issr_pkg::CONTROLLER_BIT] = CONTROLLER_ROLE;
    state_next[issr_pkg::BUSY_BIT] = busy_next;
  end

  always_comb begin
    status_next = 32'h0000_0000;
    status_next[issr_pkg::RX_VALID_BIT] = RX_NOT_EMPTY;
    // full wins so a one-entry buffer never reads both ways
    status_next[issr_pkg::TX_LEVEL_BIT] = TX_EMPTY && !TX_FULL;
    status_next[issr_pkg::TX_COMPLETE_BIT] = txc_next;
    status_next[issr_pkg::START_PEND_BIT +: 6] = pend;
  end

  assign irq_events = {timeout_hit, state_next[issr_pkg::NOT_ACKNOWLEDGED_FLAG_BIT] && !state_reg[issr_pkg::NOT_ACKNOWLEDGED_FLAG_BIT],
                       txc_next && !txc_reg};

  // interrupt flags: write one clears, a new event in the same cycle wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    timeout_next = timeout_reg;
    if (wr && PADDR == issr_pkg::ADDR_IRQ_STATUS) begin
      irq_stat_next = irq_stat_reg & ~PWDATA[issr_pkg::IRQ_WIDTH-1:0];
    end
    if (wr && PADDR == issr_pkg::ADDR_IRQ_MASK) begin
      irq_mask_next = PWDATA[issr_pkg::IRQ_WIDTH-1:0];
    end
    if (wr && PADDR == issr_pkg::ADDR_CONTROL) begin
      timeout_next = PWDATA[15:0];
    end
    irq_stat_next = irq_stat_next | irq_events;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // apb slave: one wait state, writes to report registers dropped
  always_comb begin
    pready_next = access;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (access) begin
      prdata_next = 32'h0000_0000;
      case (PADDR)
        issr_pkg::ADDR_BUS_PHASE_REPORT: begin
          prdata_next = state_reg;
        end
        issr_pkg::ADDR_BUFFER_AND_PENDING_REPORT: begin
          prdata_next = status_reg;
        end
        issr_pkg::ADDR_IRQ_STATUS: begin
          prdata_next[issr_pkg::IRQ_WIDTH-1:0] = irq_stat_reg;
        end
        issr_pkg::ADDR_IRQ_MASK: begin
          prdata_next[issr_pkg::IRQ_WIDTH-1:0] = irq_mask_reg;
        end
        issr_pkg::ADDR_CONTROL: begin
          prdata_next[15:0] = timeout_reg;
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
      if (PWRITE) begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= issr_pkg::STATE_RESET;
      status_reg <= issr_pkg::STATUS_RESET;
      busy_reg <= 1'b1;
      txc_reg <= 1'b0;
      issue_start_reg <= 1'b0;
      abort_busy_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
      timeout_reg <= issr_pkg::IDLE_TIMEOUT_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      status_reg <= status_next;
      busy_reg <= busy_next;
      txc_reg <= txc_next;
      issue_start_reg <= issue_start_next;
      abort_busy_reg <= abort_busy_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      timeout_reg <= timeout_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign ISSUE_START = issue_start_reg;
  assign ABORT_BUSY = abort_busy_reg;
  assign IRQ = irq_reg;
endmodule
`default_nettype wire

/* issr_bus_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// another controller on the bus; its lines keep changing while its frame is open
module issr_bus_peer (
  input wire logic clk, // system clock
  output logic start_seen, // start pulse
  output logic stop_seen, // stop pulse
  output logic activity // line change pulse
);
  logic in_frame = 1'h0;
  logic [1:0] cnt = 2'h0;
  initial begin
    start_seen = 1'h0;
    stop_seen = 1'h0;
  end
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
  end
  // without these pulses the idle timeout would end a live frame
  assign activity = (in_frame && cnt == 2'h0) || start_seen || stop_seen;
  task automatic frame(input logic open);
    @(posedge clk);
    start_seen <= open;
    stop_seen <= !open;
    in_frame <= open;
    @(posedge clk);
    start_seen <= 1'h0;
    stop_seen <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* issr_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
module issr_top_props (
  input wire logic CLK_SYS, // clock
  input wire logic RSTN, // reset
  input wire logic CE, // enable
  input wire logic PWRITE, // direction
  input wire logic [11:0] PADDR, // address
  input wire logic [31:0] PRDATA, // read data
  input wire logic PREADY, // ready
  input wire logic PSLVERR, // error
  input wire issr_pkg::issr_phase_t ENGINE_PHASE, // phase
  input wire logic ENGINE_ACTIVE, // active
  input wire logic HOLDING_BUS, // holding
  input wire logic NACK_RECEIVED, // nack
  input wire logic TRANSMITTING, // transmitter
  input wire logic CONTROLLER_ROLE, // controller
  input wire logic RX_NOT_EMPTY, // rx data
  input wire logic TX_FULL, // tx full
  input wire logic ISSUE_START // start issue
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // read data is a snapshot of inputs two edges old
  sequence s_st;
    PREADY && !PWRITE && !PSLVERR && PADDR == issr_pkg::ADDR_BUS_PHASE_REPORT;
  endsequence
  sequence s_su;
    PREADY && !PWRITE && !PSLVERR && PADDR == issr_pkg::ADDR_BUFFER_AND_PENDING_REPORT;
  endsequence
  AST_PHASE_IDLE: assert property ((CE && !ENGINE_ACTIVE)[*3] ##1 s_st |-> PRDATA[7:5] == 3'h0)
    else $error("phase not zero while idle");
  AST_PHASE_CODE: assert property ((CE && ENGINE_ACTIVE && $stable(ENGINE_PHASE))[*2] ##1 s_st |->
    PRDATA[7:5] == $past(ENGINE_PHASE, 2)) else $error("phase code wrong");
  AST_HELD: assert property ((CE && HOLDING_BUS)[*3] ##1 s_st |-> PRDATA[4] && PRDATA[0])
    else $error("held or busy flag missing");
  AST_NOT_ACKNOWLEDGED_FLAG: assert property ((CE && ENGINE_ACTIVE && NACK_RECEIVED &&
    ENGINE_PHASE == issr_pkg::PH_DATA_ACK)[*3] ##1 s_st |-> PRDATA[3]) else $error("nack flag missing");
  AST_TRANSMIT: assert property ((CE && $stable(TRANSMITTING))[*3] ##1 s_st |->
    PRDATA[2] == $past(TRANSMITTING, 2)) else $error("direction flag wrong");
  AST_ROLE: assert property ((CE && $stable(CONTROLLER_ROLE))[*3] ##1 s_st |->
    PRDATA[1] == $past(CONTROLLER_ROLE, 2)) else $error("role flag wrong");
  AST_RX_VALID: assert property ((CE && $stable(RX_NOT_EMPTY))[*3] ##1 s_su |->
    PRDATA[8] == $past(RX_NOT_EMPTY, 2)) else $error("rx valid wrong");
  AST_TX_FULL: assert property ((CE && TX_FULL)[*3] ##1 s_su |-> !PRDATA[7])
    else $error("tx level high while full");
  AST_ISSUE_START: assert property ($rose(ISSUE_START) |-> $past(ENGINE_PHASE) == issr_pkg::PH_WAITING)
    else $error("start issued outside waiting");
endmodule
bind issr_top issr_top_props u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ENGINE_PHASE(ENGINE_PHASE), .ENGINE_ACTIVE(ENGINE_ACTIVE),
  .HOLDING_BUS(HOLDING_BUS), .NACK_RECEIVED(NACK_RECEIVED), .TRANSMITTING(TRANSMITTING),
  .CONTROLLER_ROLE(CONTROLLER_ROLE), .RX_NOT_EMPTY(RX_NOT_EMPTY), .TX_FULL(TX_FULL), .ISSUE_START(ISSUE_START));
`default_nettype wire

/* issr_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module issr_top_test;
  localparam logic [11:0] ST = issr_pkg::ADDR_BUS_PHASE_REPORT;
  localparam logic [11:0] SU = issr_pkg::ADDR_BUFFER_AND_PENDING_REPORT;
  localparam logic [11:0] IS = issr_pkg::ADDR_IRQ_STATUS;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy, perr, ss, sp, act, iss, abt, irq;
  issr_pkg::issr_cmd_t cmd = '0;
  issr_pkg::issr_done_t done = '0;
  issr_pkg::issr_phase_t phase = issr_pkg::PH_IDLE;
  logic active = 1'h0;
  logic hold = 1'h0;
  logic nack = 1'h0;
  logic tx = 1'h0;
  logic ctl = 1'h0;
  logic rxne = 1'h0;
  logic txe = 1'h1;
  logic txf = 1'h0;
  logic xend = 1'h0;
  logic xbeg = 1'h0;
  int num_errors = 0;
  int num_checks = 0;
  issr_top dut (.CLK_SYS(clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .CMD(cmd), .DONE(done), .ENGINE_PHASE(phase),
    .ENGINE_ACTIVE(active), .BUS_START_SEEN(ss), .BUS_STOP_SEEN(sp), .BUS_ACTIVITY(act), .HOLDING_BUS(hold),
    .NACK_RECEIVED(nack), .TRANSMITTING(tx), .CONTROLLER_ROLE(ctl), .RX_NOT_EMPTY(rxne), .TX_EMPTY(txe),
    .TX_FULL(txf), .TRANSFER_END(xend), .TRANSFER_BEGIN(xbeg), .ISSUE_START(iss), .ABORT_BUSY(abt), .IRQ(irq));
  issr_bus_peer peer (.clk(clk), .start_seen(ss), .stop_seen(sp), .activity(act));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    q = prd;
    e = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, exp);
    // only an unmapped offset answers with an error
    chk({31'h0, e}, {31'h0, !(a inside {ST, SU, IS, issr_pkg::ADDR_IRQ_MASK, issr_pkg::ADDR_CONTROL})});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic strobe(input logic [6:0] c, input logic [5:0] d, input logic te, input logic tb);
    @(posedge clk);
    cmd <= c;
    done <= d;
    xend <= te;
    xbeg <= tb;
    @(posedge clk);
    cmd <= '0;
    done <= '0;
    xend <= 1'h0;
    xbeg <= 1'h0;
  endtask
  task automatic wait_out(input logic sel);
    int n;
    n = 0;
    while ((sel ? abt : iss) !== 1'h1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n < 600}, 32'h1);
    if (n >= 600) finish_test();
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    rd(ST, 32'h1);
    rd(SU, 32'h80);
    wr(ST, 32'hffff_ffff);
    rd(ST, 32'h1);
    wr(SU, 32'h0000_01ff);
    rd(SU, 32'h80);
    rd(12'h030, 32'h0); // unmapped: error flag, data zero
    $display("test reset done");
    wr(issr_pkg::ADDR_CONTROL, 32'h14);
    wait_out(1'h1);
    rd(ST, 32'h0);
    peer.frame(1'h1);
    rd(ST, 32'h1);
    peer.frame(1'h0);
    rd(ST, 32'h0);
    $display("test busy done");
    active <= 1'h1;
    for (int p = 0; p < 7; p++) begin
      phase <= issr_pkg::issr_phase_t'(p);
      rd(ST, {24'h0, 3'(p), 5'h0});
    end
    nack <= 1'h1;
    rd(ST, 32'hc8);
    phase <= issr_pkg::PH_DATA;
    rd(ST, 32'ha0);
    nack <= 1'h0;
    active <= 1'h0;
    rd(ST, 32'h0);
    tx <= 1'h1;
    ctl <= 1'h1;
    rd(ST, 32'h6);
    tx <= 1'h0;
    ctl <= 1'h0;
    hold <= 1'h1;
    rd(ST, 32'h11);
    hold <= 1'h0;
    peer.frame(1'h1);
    peer.frame(1'h0);
    $display("test state done");
    for (int i = 0; i < 6; i++) begin
      strobe(7'h40 >> i, 6'h00, 1'h0, 1'h0);
      rd(SU, 32'h80 | (32'h1 << i));
      strobe(7'h00, 6'h20 >> i, 1'h0, 1'h0);
      rd(SU, 32'h80);
    end
    strobe(7'h7e, 6'h00, 1'h0, 1'h0);
    rd(SU, 32'hbf);
    strobe(7'h01, 6'h00, 1'h0, 1'h0);
    rd(SU, 32'h80);
    peer.frame(1'h1);
    strobe(7'h02, 6'h00, 1'h0, 1'h0);
    strobe(7'h00, 6'h01, 1'h0, 1'h0);
    wait_out(1'h1);
    rd(ST, 32'h0);
    peer.frame(1'h0);
    active <= 1'h1;
    phase <= issr_pkg::PH_WAITING;
    peer.frame(1'h1);
    strobe(7'h40, 6'h00, 1'h0, 1'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, iss}, 32'h0);
    peer.frame(1'h0);
    wait_out(1'h0);
    strobe(7'h00, 6'h20, 1'h0, 1'h0);
    active <= 1'h0;
    $display("test pending done");
    ce <= 1'h0;
    strobe(7'h40, 6'h00, 1'h0, 1'h0);
    ce <= 1'h1;
    rd(SU, 32'h80); // frozen clock enable drops the request
    rxne <= 1'h1;
    rd(SU, 32'h180);
    rxne <= 1'h0;
    txe <= 1'h0;
    txf <= 1'h1;
    rd(SU, 32'h0);
    txe <= 1'h1;
    txf <= 1'h0;
    wr(IS, 32'h7); // drop stale events
    strobe(7'h00, 6'h00, 1'h1, 1'h0);
    rd(SU, 32'hc0);
    chk({31'h0, irq}, 32'h0); // masked event keeps the line low
    wr(issr_pkg::ADDR_IRQ_MASK, 32'h1); // unmask tx complete
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(IS, 32'h1);
    wr(IS, 32'h1); // write one clears
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0); // cleared event drops the line
    strobe(7'h00, 6'h00, 1'h0, 1'h1);
    rd(SU, 32'h80);
    $display("test status done");
    finish_test();
  end
endmodule
`default_nettype wire
